// >>> logic/cbu_branch_unit.sv
// Conditional relative branch unit: flag test and program counter target
`timescale 1ns/1ps

// What this block does
// - Flag-set branch tests indexed status bit; if 1, PC becomes PC plus offset plus one.
// - Flag-clear branch jumps when indexed status bit is 0, else falls through.
// - Branch on equal jumps only when zero flag is 1.
// - Branch on not equal jumps only when zero flag is 0.
// - Branch on carry set jumps only when carry flag is 1.
// - Branch on carry clear jumps when carry is 0; no status flag changes.
// - Same-or-higher equals carry clear; one cycle not taken, two taken.
module cbu_branch_unit
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire cbu_pkg::cbu_req_t req_in,
    input wire logic [cbu_pkg::FLAG_W-1:0] status_flags_register_in,
    input wire logic [cbu_pkg::PC_W-1:0] pc_in,
    output logic busy_out,
    output cbu_pkg::cbu_resp_t resp_out,
    output logic [cbu_pkg::FLAG_W-1:0] status_flags_out
);
    cbu_pkg::cbu_regs_t state_reg;
    cbu_pkg::cbu_regs_t state_next;
    logic flag_bit;
    logic cond;
    logic [cbu_pkg::PC_W-1:0] ofs_ext;
    logic accept;

    // Flags pass through untouched by any branch
    assign status_flags_out = status_flags_register_in;
    assign busy_out = state_reg.busy;
    assign resp_out = state_reg.resp;
    assign accept = req_in.valid && (state_reg.state == cbu_pkg::CBU_ST_IDLE);

    // Sign extension of the offset
    assign ofs_ext = {{(cbu_pkg::PC_W-cbu_pkg::OFS_W){req_in.offset[cbu_pkg::OFS_W-1]}}, req_in.offset};

    // Condition evaluation per branch kind
    always_comb
    begin
        flag_bit = status_flags_register_in[req_in.index];
        cond = 1'b0;
        unique case (req_in.op)
            cbu_pkg::CBU_OP_FLAG_SET: cond = flag_bit;
            cbu_pkg::CBU_OP_FLAG_CLEAR: cond = !flag_bit;
            cbu_pkg::CBU_OP_EQUAL: cond = status_flags_register_in[cbu_pkg::ZERO_BIT];
            cbu_pkg::CBU_OP_NOT_EQUAL: cond = !status_flags_register_in[cbu_pkg::ZERO_BIT];
            cbu_pkg::CBU_OP_CARRY_SET: cond = status_flags_register_in[cbu_pkg::CARRY_BIT];
            cbu_pkg::CBU_OP_CARRY_CLEAR,
            cbu_pkg::CBU_OP_SAME_HIGHER: cond = !status_flags_register_in[cbu_pkg::CARRY_BIT];
            cbu_pkg::CBU_OP_NONE: cond = 1'b0;
        endcase
    end

    // Next state: answer next cycle; a taken branch holds busy one extra cycle
    always_comb
    begin
        state_next = state_reg;
        state_next.resp.done = 1'b0;
        state_next.resp.taken = 1'b0;
        unique case (state_reg.state)
            cbu_pkg::CBU_ST_IDLE:
            begin
                state_next.busy = 1'b0;
                if (accept && req_in.op != cbu_pkg::CBU_OP_NONE)
                begin
                    if (cond)
                    begin
                        state_next.state = cbu_pkg::CBU_ST_TAKEN;
                        state_next.busy = 1'b1;
                        state_next.resp.target = pc_in + ofs_ext + cbu_pkg::PC_ONE;
                    end
                    else
                    begin
                        state_next.resp.done = 1'b1;
                        state_next.resp.target = pc_in + cbu_pkg::PC_ONE;
                    end
                end
            end
            cbu_pkg::CBU_ST_TAKEN:
            begin
                state_next.state = cbu_pkg::CBU_ST_IDLE;
                state_next.busy = 1'b0;
                state_next.resp.done = 1'b1;
                state_next.resp.taken = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            state_reg.state <= cbu_pkg::CBU_ST_IDLE;
            state_reg.busy <= 1'b0;
            state_reg.resp.done <= 1'b0;
            state_reg.resp.taken <= 1'b0;
            state_reg.resp.target <= cbu_pkg::PC_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Checks on decisions, targets and timing of every branch kind

    // Flag-set branch taken: relative target two cycles after accept
    a_taken_target: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_FLAG_SET && status_flags_register_in[req_in.index])
        |-> ##2 (resp_out.done && resp_out.taken
        && resp_out.target == $past(pc_in, 2) + $past(ofs_ext, 2) + cbu_pkg::PC_ONE))
        else $error("flag-set branch target wrong");

    // Flag-set branch not taken: falls through one cycle after accept
    a_set_fall: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_FLAG_SET && !status_flags_register_in[req_in.index])
        |=> (resp_out.done && !resp_out.taken && resp_out.target == $past(pc_in) + cbu_pkg::PC_ONE))
        else $error("flag-set branch did not fall through");

    // Flag-clear branch with the bit set falls through
    a_clear_fall: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_FLAG_CLEAR && status_flags_register_in[req_in.index])
        |=> (resp_out.done && !resp_out.taken && resp_out.target == $past(pc_in) + cbu_pkg::PC_ONE))
        else $error("flag-clear branch did not fall through");

    // Flag-clear branch with the bit clear jumps to the relative target
    a_clear_taken: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_FLAG_CLEAR && !status_flags_register_in[req_in.index])
        |-> ##2 (resp_out.done && resp_out.taken
        && resp_out.target == $past(pc_in, 2) + $past(ofs_ext, 2) + cbu_pkg::PC_ONE))
        else $error("flag-clear branch target wrong");

    // Equal branch decision follows the zero flag
    a_equal_taken: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_EQUAL)
        |=> (busy_out == $past(status_flags_register_in[cbu_pkg::ZERO_BIT])))
        else $error("equal branch decision wrong");

    // Equal branch with zero clear answers at once
    a_equal_fall: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_EQUAL && !status_flags_register_in[cbu_pkg::ZERO_BIT])
        |=> (resp_out.done && !resp_out.taken))
        else $error("equal branch taken with zero clear");

    // Not-equal branch decision is the inverse of the zero flag
    a_noteq_taken: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_NOT_EQUAL)
        |=> (busy_out != $past(status_flags_register_in[cbu_pkg::ZERO_BIT])))
        else $error("not-equal branch decision wrong");

    // Not-equal branch with zero set answers at once
    a_noteq_fall: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_NOT_EQUAL && status_flags_register_in[cbu_pkg::ZERO_BIT])
        |=> (resp_out.done && !resp_out.taken))
        else $error("not-equal branch taken with zero set");

    // Carry-set branch decision follows the carry flag
    a_carry_set: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_CARRY_SET)
        |=> (busy_out == $past(status_flags_register_in[cbu_pkg::CARRY_BIT])))
        else $error("carry-set branch decision wrong");

    // Carry-set branch with carry clear answers at once
    a_carry_fall: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_CARRY_SET && !status_flags_register_in[cbu_pkg::CARRY_BIT])
        |=> (resp_out.done && !resp_out.taken))
        else $error("carry-set branch taken with carry clear");

    // Carry-clear branch decision is the inverse of the carry flag
    a_carry_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_CARRY_CLEAR)
        |=> (busy_out != $past(status_flags_register_in[cbu_pkg::CARRY_BIT])))
        else $error("carry-clear branch decision wrong");

    // Flags leave the unit exactly as they came in
    a_flags_kept: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (status_flags_out == status_flags_register_in))
        else $error("branch altered status flags");

    // Same-or-higher not taken completes in one cycle
    a_one_cycle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_SAME_HIGHER && status_flags_register_in[cbu_pkg::CARRY_BIT])
        |=> (resp_out.done && !busy_out))
        else $error("not-taken branch not done in one cycle");

    // Same-or-higher taken completes in two cycles
    a_two_cycle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_SAME_HIGHER && !status_flags_register_in[cbu_pkg::CARRY_BIT])
        |=> (busy_out && !resp_out.done) ##1 (resp_out.done && resp_out.taken))
        else $error("taken branch not done in two cycles");

    // Busy never lasts longer than the one extra cycle
    a_busy_short: assert property (@(posedge core_clk_in) disable iff (rst_in)
        busy_out |=> !busy_out)
        else $error("busy held beyond one cycle");

    // A request arriving while busy must not disturb the pending target
    a_target_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
        busy_out |=> $stable(resp_out.target))
        else $error("target changed while busy");

    // An empty request gives neither answer nor busy
    a_none_quiet: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && req_in.op == cbu_pkg::CBU_OP_NONE)
        |=> (!resp_out.done && !busy_out))
        else $error("empty request produced an answer");

    // Taken target uses the offset sign-extended from its top bit
    a_sign_ext: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (accept && cond)
        |=> (resp_out.target == $past(pc_in)
        + {{(cbu_pkg::PC_W-cbu_pkg::OFS_W){$past(req_in.offset[cbu_pkg::OFS_W-1])}}, $past(req_in.offset)}
        + cbu_pkg::PC_ONE))
        else $error("offset not sign extended");

    // Main scenarios to be reached
    c_taken: cover property (@(posedge core_clk_in) resp_out.done && resp_out.taken);
    c_not_taken: cover property (@(posedge core_clk_in) resp_out.done && !resp_out.taken);
    c_backward: cover property (@(posedge core_clk_in) accept && req_in.offset[cbu_pkg::OFS_W-1] && cond);
    c_refused: cover property (@(posedge core_clk_in) busy_out && req_in.valid);
endmodule

// >>> common/cbu_pkg.sv
// Package for the conditional branch unit: widths, flag positions, opcodes, states and carriers
package cbu_pkg;
    localparam int PC_W = 12;
    localparam int OFS_W = 7;
    localparam int FLAG_W = 8;
    localparam int IDX_W = 3;
    localparam logic [IDX_W-1:0] CARRY_BIT = 3'h0;
    localparam logic [IDX_W-1:0] ZERO_BIT = 3'h1;
    localparam logic [PC_W-1:0] PC_ONE = 12'h001;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;

    // Branch kinds presented by the decoder
    typedef enum logic [2:0]
    {
        CBU_OP_FLAG_SET = 3'b000,
        CBU_OP_FLAG_CLEAR = 3'b001,
        CBU_OP_EQUAL = 3'b010,
        CBU_OP_NOT_EQUAL = 3'b011,
        CBU_OP_CARRY_SET = 3'b100,
        CBU_OP_CARRY_CLEAR = 3'b101,
        CBU_OP_SAME_HIGHER = 3'b110,
        CBU_OP_NONE = 3'b111
    } cbu_op_t;

    typedef enum logic
    {
        CBU_ST_IDLE = 1'b0,
        CBU_ST_TAKEN = 1'b1
    } cbu_state_t;

    // One branch request from the decoder
    typedef struct packed
    {
        logic valid;
        cbu_op_t op;
        logic [IDX_W-1:0] index;
        logic [OFS_W-1:0] offset;
    } cbu_req_t;

    // Answer toward fetch and program counter
    typedef struct packed
    {
        logic done;
        logic taken;
        logic [PC_W-1:0] target;
    } cbu_resp_t;

    // All state of the unit
    typedef struct packed
    {
        cbu_state_t state;
        logic busy;
        cbu_resp_t resp;
    } cbu_regs_t;
endpackage

// >>> sim/cbu_pc_model.sv
// Program counter model on the fetch side of the branch unit
`timescale 1ns/1ps
module cbu_pc_model
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire cbu_pkg::cbu_resp_t resp_in,
    output logic [cbu_pkg::PC_W-1:0] pc_out
);
    // Load the answered target once a branch completes
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            pc_out <= 12'h010;
        else if (resp_in.done)
            pc_out <= resp_in.target;
    end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the conditional branch unit
`timescale 1ns/1ps
module testbench;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    cbu_pkg::cbu_req_t req = '0;
    logic [7:0] flags = 8'h00;
    logic [11:0] pc;
    logic busy;
    cbu_pkg::cbu_resp_t resp;
    logic [7:0] flags_seen;
    int failures = 0;
    int num_checks = 0;
    cbu_branch_unit uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req),
        .status_flags_register_in(flags), .pc_in(pc), .busy_out(busy), .resp_out(resp),
        .status_flags_out(flags_seen));
    cbu_pc_model pcm (.core_clk_in(core_clk_in), .rst_in(rst_in), .resp_in(resp), .pc_out(pc));
    // Clock generator
    initial
    begin
        forever #5 core_clk_in = ~core_clk_in;
    end
    task automatic end_of_test();
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One branch request, judged on outcome, target, timing and flags
    task automatic branch(input cbu_pkg::cbu_op_t op, input logic [2:0] idx, input logic [6:0] ofs,
        input logic [7:0] fl, input logic tk);
        logic [11:0] exp_t;
        int n;
        @(negedge core_clk_in);
        exp_t = pc + (tk ? {{5{ofs[6]}}, ofs} : 12'h000) + 12'h001;
        req = '{1'b1, op, idx, ofs};
        flags = fl;
        n = 0;
        @(negedge core_clk_in);
        req.valid = 1'b0;
        check("busy", {15'h0000, busy}, {15'h0000, tk});
        while (resp.done !== 1'b1 && n < 8)
        begin
            @(negedge core_clk_in);
            n++;
        end
        check("flags", {8'h00, flags_seen}, {8'h00, fl});
        check("taken", {15'h0000, resp.taken}, {15'h0000, tk});
        check("target", {4'h0, resp.target}, {4'h0, exp_t});
        check("cycles", n[15:0], tk ? 16'h0001 : 16'h0000);
        if (n == 8)
            end_of_test();
    endtask
    // Indexed flag branches over every bit, with backward and forward offsets
    task automatic t_indexed();
        for (int i = 0; i < 8; i++)
        begin
            branch(cbu_pkg::CBU_OP_FLAG_SET, i[2:0], 7'h7C, 8'h01 << i, 1'b1);
            branch(cbu_pkg::CBU_OP_FLAG_SET, i[2:0], 7'h05, ~(8'h01 << i), 1'b0);
            branch(cbu_pkg::CBU_OP_FLAG_CLEAR, i[2:0], 7'h40, ~(8'h01 << i), 1'b1);
            branch(cbu_pkg::CBU_OP_FLAG_CLEAR, i[2:0], 7'h3F, 8'h01 << i, 1'b0);
        end
    endtask
    // Zero flag branches
    task automatic t_zero();
        branch(cbu_pkg::CBU_OP_EQUAL, 3'h0, 7'h7F, 8'h02, 1'b1);
        branch(cbu_pkg::CBU_OP_EQUAL, 3'h0, 7'h11, 8'hFD, 1'b0);
        branch(cbu_pkg::CBU_OP_NOT_EQUAL, 3'h0, 7'h3F, 8'hFD, 1'b1);
        branch(cbu_pkg::CBU_OP_NOT_EQUAL, 3'h0, 7'h22, 8'h02, 1'b0);
    endtask
    // Carry flag branches, same-or-higher alike to carry clear
    task automatic t_carry();
        branch(cbu_pkg::CBU_OP_CARRY_SET, 3'h0, 7'h70, 8'h01, 1'b1);
        branch(cbu_pkg::CBU_OP_CARRY_SET, 3'h0, 7'h12, 8'hFE, 1'b0);
        branch(cbu_pkg::CBU_OP_CARRY_CLEAR, 3'h0, 7'h0A, 8'hFE, 1'b1);
        branch(cbu_pkg::CBU_OP_CARRY_CLEAR, 3'h0, 7'h0A, 8'h01, 1'b0);
        branch(cbu_pkg::CBU_OP_SAME_HIGHER, 3'h0, 7'h60, 8'hAE, 1'b1);
        branch(cbu_pkg::CBU_OP_SAME_HIGHER, 3'h0, 7'h60, 8'h51, 1'b0);
    endtask
    // An empty request must give no answer at all
    task automatic t_none();
        @(negedge core_clk_in);
        req = '{1'b1, cbu_pkg::CBU_OP_NONE, 3'h0, 7'h05};
        @(negedge core_clk_in);
        req.valid = 1'b0;
        check("none busy", {15'h0000, busy}, 16'h0000);
        check("none done", {15'h0000, resp.done}, 16'h0000);
        @(negedge core_clk_in);
        check("none late", {15'h0000, resp.done}, 16'h0000);
    endtask
    // A second request held during a taken branch is ignored
    task automatic t_refused();
        logic [11:0] exp_t;
        @(negedge core_clk_in);
        exp_t = pc + 12'h003 + 12'h001;
        req = '{1'b1, cbu_pkg::CBU_OP_CARRY_SET, 3'h0, 7'h03};
        flags = 8'h01;
        @(negedge core_clk_in);
        req.offset = 7'h20;
        check("refused busy", {15'h0000, busy}, 16'h0001);
        @(negedge core_clk_in);
        req.valid = 1'b0;
        check("refused done", {15'h0000, resp.done}, 16'h0001);
        check("refused target", {4'h0, resp.target}, {4'h0, exp_t});
    endtask
    // Reset, then the scenarios
    initial
    begin
        repeat (16) @(negedge core_clk_in);
        rst_in = 1'b0;
        t_indexed();
        t_zero();
        t_carry();
        t_none();
        t_refused();
        end_of_test();
    end
endmodule
